// [shared/rcd_pkg.sv]
// Constants shared by the reset-cause and debug force-reset block
package rcd_pkg;

    // Register width and bit positions of the reset-cause register
    localparam int unsigned REG_W = 8;
    localparam int unsigned BIT_POWER_UP = 7;
    localparam int unsigned BIT_EXT_PIN = 6;
    localparam int unsigned BIT_WATCHDOG = 5;
    localparam int unsigned BIT_BAD_OPCODE = 4;
    localparam int unsigned BIT_BAD_ADDRESS = 3;
    localparam int unsigned BIT_EXT_OSC_FAIL = 2;
    localparam int unsigned BIT_LOW_VOLTAGE = 1;
    localparam int unsigned BIT_CAUSE_ZERO = 0;

    // Bit position of the force-reset control bit
    localparam int unsigned BIT_DEBUG_FORCE = 0;

    // Reset values of the reset-cause register
    localparam logic [7:0] CAUSE_AT_POWER_ON = 8'h82;
    localparam logic [7:0] CAUSE_AT_LOW_VOLTAGE = 8'h02;
    localparam logic [7:0] CAUSE_AT_DEBUG_FORCE = 8'h00;

    // Read value of the force-reset register
    localparam logic [7:0] FORCE_READ_VALUE = 8'h00;

    // Watchdog service sequence
    localparam logic [7:0] SERVICE_FIRST = 8'h55;
    localparam logic [7:0] SERVICE_SECOND = 8'haa;

    // Timeout selection that turns the watchdog off
    localparam logic [1:0] WDOG_SEL_OFF = 2'h0;

    // Timing: minimum length of the reset pulse driven to the core
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RESET_HOLD_NS = 320;
    localparam int unsigned RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        ST_RUN,
        ST_IN_RESET
    } rcd_state_t;

endpackage

// [design/rcd_reset_cause.sv]
// Reset-cause status register, watchdog service decode and debug force reset
module rcd_reset_cause #(
    parameter int unsigned HOLD_CYC = rcd_pkg::RESET_HOLD_CYC
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    // Register access
    input wire logic i_cause_sel,
    input wire logic i_force_sel,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wr_from_debug,
    input wire logic [7:0] i_wdata,
    // Reset sources and their enables
    input wire logic i_ext_pin_rst_b,
    input wire logic i_wdog_timeout,
    input wire logic [1:0] i_watchdog_timeout_sel,
    input wire logic i_watchdog_window_en,
    input wire logic i_wdog_window_open,
    input wire logic i_bad_opcode,
    input wire logic i_stop_exec,
    input wire logic i_stop_allow,
    input wire logic i_enter_debug_instr,
    input wire logic i_bkgd_mode_allow,
    input wire logic i_bad_addr_access,
    input wire logic i_ext_osc_fail,
    input wire logic i_low_voltage_trip,
    input wire logic i_brownout_reset_en,
    // Results
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic [7:0] o_reset_cause_reg,
    output logic o_mcu_reset,
    output logic o_wdog_restart
);

    // Flags for any reset other than power-on, low-voltage or debug force
    function automatic logic [7:0] other_flags(
        input logic pin,
        input logic wdog,
        input logic opc,
        input logic adr,
        input logic osc
    );
        logic [7:0] f;
        f = 8'h00;
        f[rcd_pkg::BIT_EXT_PIN] = pin;
        f[rcd_pkg::BIT_WATCHDOG] = wdog;
        f[rcd_pkg::BIT_BAD_OPCODE] = opc;
        f[rcd_pkg::BIT_BAD_ADDRESS] = adr;
        f[rcd_pkg::BIT_EXT_OSC_FAIL] = osc;
        return f;
    endfunction

    rcd_pkg::rcd_state_t state_r, state_nxt;
    logic [7:0] reset_cause_reg_r, reset_cause_reg_nxt;
    logic [15:0] hold_cnt_r, hold_cnt_nxt;
    logic service_armed_r, service_armed_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rdata_valid_r, rdata_valid_nxt;
    logic mcu_reset_r, mcu_reset_nxt;
    logic wdog_restart_r, wdog_restart_nxt;

    logic wdog_on;
    logic cause_wr;
    logic force_wr;
    logic wr_trip;
    logic wdog_src;
    logic opc_src;
    logic pin_src;
    logic lvd_src;
    logic debug_src;
    logic any_src;

    // Source decode; writes are only honoured while the core runs
    always_comb begin
        wdog_on = (i_watchdog_timeout_sel != rcd_pkg::WDOG_SEL_OFF);
        cause_wr = (state_r == rcd_pkg::ST_RUN) && i_wr && i_cause_sel;
        // User-program writes never reach the force bit
        force_wr = (state_r == rcd_pkg::ST_RUN) && i_wr && i_force_sel
            && i_wr_from_debug;
        debug_src = force_wr && i_wdata[rcd_pkg::BIT_DEBUG_FORCE];
        wr_trip = 1'b0;
        if (cause_wr && wdog_on) begin
            if (i_watchdog_window_en && !i_wdog_window_open) begin
                wr_trip = 1'b1;
            end else if (i_wdata != rcd_pkg::SERVICE_FIRST
                    && i_wdata != rcd_pkg::SERVICE_SECOND) begin
                wr_trip = 1'b1;
            end
        end
        // A timeout cannot occur while the watchdog is switched off
        wdog_src = (wdog_on && i_wdog_timeout) || wr_trip;
        opc_src = i_bad_opcode
            || (i_stop_exec && !i_stop_allow)
            || (i_enter_debug_instr && !i_bkgd_mode_allow);
        pin_src = !i_ext_pin_rst_b;
        lvd_src = i_brownout_reset_en && i_low_voltage_trip;
        any_src = wdog_src || opc_src || pin_src || lvd_src || debug_src
            || i_bad_addr_access || i_ext_osc_fail;
    end

    // Next-state logic for the sequencer, flags and bus answers
    always_comb begin
        state_nxt = state_r;
        reset_cause_reg_nxt = reset_cause_reg_r;
        hold_cnt_nxt = hold_cnt_r;
        service_armed_nxt = service_armed_r;
        rdata_nxt = rdata_r;
        rdata_valid_nxt = 1'b0;
        mcu_reset_nxt = mcu_reset_r;
        wdog_restart_nxt = 1'b0;

        case (state_r)
            rcd_pkg::ST_RUN: begin
                if (any_src) begin
                    // Capture happens only here, at reset entry
                    if (lvd_src) begin
                        reset_cause_reg_nxt = rcd_pkg::CAUSE_AT_LOW_VOLTAGE;
                    end else if (debug_src) begin
                        reset_cause_reg_nxt = rcd_pkg::CAUSE_AT_DEBUG_FORCE;
                    end else begin
                        reset_cause_reg_nxt = other_flags(pin_src, wdog_src, opc_src,
                            i_bad_addr_access, i_ext_osc_fail);
                    end
                    state_nxt = rcd_pkg::ST_IN_RESET;
                    hold_cnt_nxt = 16'(HOLD_CYC - 1);
                    mcu_reset_nxt = 1'b1;
                    service_armed_nxt = 1'b0;
                end else if (cause_wr) begin
                    // Service sequence: 0x55 arms, 0xAA completes
                    if (i_wdata == rcd_pkg::SERVICE_FIRST) begin
                        service_armed_nxt = 1'b1;
                    end else if (i_wdata == rcd_pkg::SERVICE_SECOND) begin
                        wdog_restart_nxt = service_armed_r;
                        service_armed_nxt = 1'b0;
                    end
                end
                if (i_rd && !any_src) begin
                    rdata_valid_nxt = 1'b1;
                    if (i_cause_sel) begin
                        rdata_nxt = reset_cause_reg_r;
                    end else if (i_force_sel) begin
                        rdata_nxt = rcd_pkg::FORCE_READ_VALUE;
                    end else begin
                        rdata_nxt = 8'h00;
                    end
                end
            end
            rcd_pkg::ST_IN_RESET: begin
                // A pin, low-voltage or oscillator-fail source that stays active stretches the reset
                if (pin_src || lvd_src || i_ext_osc_fail) begin
                    hold_cnt_nxt = 16'(HOLD_CYC - 1);
                end else if (hold_cnt_r != 16'h0000) begin
                    hold_cnt_nxt = hold_cnt_r - 16'h0001;
                end else begin
                    state_nxt = rcd_pkg::ST_RUN;
                    mcu_reset_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = rcd_pkg::ST_RUN;
            end
        endcase
        // Bit 0 is never stored as one
        reset_cause_reg_nxt[rcd_pkg::BIT_CAUSE_ZERO] = 1'b0;
    end

    // Block reset is the power-on reset
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_r <= rcd_pkg::ST_RUN;
            reset_cause_reg_r <= rcd_pkg::CAUSE_AT_POWER_ON;
            hold_cnt_r <= 16'h0000;
            service_armed_r <= 1'b0;
            rdata_r <= 8'h00;
            rdata_valid_r <= 1'b0;
            mcu_reset_r <= 1'b0;
            wdog_restart_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            reset_cause_reg_r <= reset_cause_reg_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            service_armed_r <= service_armed_nxt;
            rdata_r <= rdata_nxt;
            rdata_valid_r <= rdata_valid_nxt;
            mcu_reset_r <= mcu_reset_nxt;
            wdog_restart_r <= wdog_restart_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rdata_valid = rdata_valid_r;
    assign o_reset_cause_reg = reset_cause_reg_r;
    assign o_mcu_reset = mcu_reset_r;
    assign o_wdog_restart = wdog_restart_r;

endmodule

// [dv/rcd_reset_cause_sva.sv]
// Port assertions for the reset-cause block
module rcd_reset_cause_sva (
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    input wire logic i_cause_sel,
    input wire logic i_force_sel,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wr_from_debug,
    input wire logic [7:0] i_wdata,
    input wire logic [1:0] i_watchdog_timeout_sel,
    input wire logic i_low_voltage_trip,
    input wire logic i_brownout_reset_en,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic [7:0] o_reset_cause_reg,
    input wire logic o_mcu_reset,
    input wire logic o_wdog_restart
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    wire logic lv = i_low_voltage_trip && i_brownout_reset_en;
    wire logic cw = i_wr && i_cause_sel && !o_mcu_reset;
    a_bit0_zero: assert property (o_reset_cause_reg[0] == 1'b0)
        else $error("cause bit 0 set");
    a_read_flags: assert property (i_rd && i_cause_sel && !o_mcu_reset
        |=> o_mcu_reset || (o_rdata_valid && o_rdata == o_reset_cause_reg))
        else $error("cause read wrong");
    a_force_reads_zero: assert property (i_rd && i_force_sel && !i_cause_sel && !o_mcu_reset
        |=> o_mcu_reset || (o_rdata_valid && o_rdata == 8'h00))
        else $error("force register read not zero");
    a_force_resets: assert property (i_wr && i_force_sel && i_wr_from_debug && i_wdata[0]
        && !i_cause_sel && !o_mcu_reset && !lv |=> o_mcu_reset && o_reset_cause_reg == 8'h00)
        else $error("debug force reset wrong");
    a_flags_hold: assert property (!$rose(o_mcu_reset) |-> $stable(o_reset_cause_reg))
        else $error("flags changed without reset");
    a_bad_write_trips: assert property (cw && i_watchdog_timeout_sel != 2'h0
        && i_wdata != 8'h55 && i_wdata != 8'haa |=> o_mcu_reset)
        else $error("bad service value did not reset");
    a_service_restart: assert property (cw && i_wdata == 8'haa && $past(cw && i_wdata == 8'h55)
        && i_watchdog_timeout_sel != 2'h0 && !lv |=> o_wdog_restart || o_mcu_reset)
        else $error("service sequence did not restart");
    a_low_voltage: assert property (lv && !o_mcu_reset
        |=> o_mcu_reset && o_reset_cause_reg == 8'h02)
        else $error("low voltage reset wrong");
endmodule

// [dv/rcd_host_model.sv]
// Software and serial debug host issuing register accesses
module rcd_host_model (
    input wire logic clk,
    output logic cause_sel = 1'b0,
    output logic force_sel = 1'b0,
    output logic wr = 1'b0,
    output logic rd = 1'b0,
    output logic dbg = 1'b0,
    output logic [7:0] wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // One access per call; calls may follow back to back
    task automatic acc(input logic c, input logic f, input logic w, input logic d,
                       input logic [7:0] v);
        @(posedge clk);
        cause_sel <= c;
        force_sel <= f;
        wr <= w;
        rd <= !w;
        dbg <= d;
        wdata <= v;
    endtask
    // Released data shows the inverse so stale values never look valid
    task automatic idle;
        @(posedge clk);
        cause_sel <= 1'b0;
        force_sel <= 1'b0;
        wr <= 1'b0;
        rd <= 1'b0;
        dbg <= 1'b0;
        wdata <= ~wdata;
    endtask
endmodule

// [dv/rcd_reset_cause_tb.sv]
// Self-checking bench for the reset-cause block
module rcd_reset_cause_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, pin_b, wdt, opc, adr, osc, lvt, stp, dbi, win_en, win_open;
    logic cs, fs, wr, rd, dbg, valid, mrst, restart;
    logic [1:0] tsel;
    logic [7:0] wd, rdata, cause, rv;
    logic [7:0] q[$];
    logic [7:0] ex[11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h10, 8'h10, 8'h20,
                           8'h20, 8'h00};
    int n_errors = 0;
    int n_compared = 0;
    rcd_host_model rcd_host_model_i (.clk(clk), .cause_sel(cs), .force_sel(fs), .wr(wr),
        .rd(rd), .dbg(dbg), .wdata(wd));
    rcd_reset_cause #(.HOLD_CYC(2)) rcd_reset_cause_i (.I_REF_CLK(clk), .I_RST_B(rst_b),
        .i_cause_sel(cs), .i_force_sel(fs), .i_wr(wr), .i_rd(rd), .i_wr_from_debug(dbg),
        .i_wdata(wd), .i_ext_pin_rst_b(pin_b), .i_wdog_timeout(wdt),
        .i_watchdog_timeout_sel(tsel), .i_watchdog_window_en(win_en),
        .i_wdog_window_open(win_open), .i_bad_opcode(opc), .i_stop_exec(stp),
        .i_stop_allow(1'b0), .i_enter_debug_instr(dbi), .i_bkgd_mode_allow(1'b0),
        .i_bad_addr_access(adr), .i_ext_osc_fail(osc), .i_low_voltage_trip(lvt),
        .i_brownout_reset_en(1'b1), .o_rdata(rdata), .o_rdata_valid(valid),
        .o_reset_cause_reg(cause), .o_mcu_reset(mrst), .o_wdog_restart(restart));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) if (valid === 1'b1) chk("read data", q.pop_front(), rdata);
    task automatic rd_exp(input logic c, input logic [7:0] e);
        q.push_back(e);
        rcd_host_model_i.acc(c, !c, 1'b0, 1'b0, 8'h00);
        rcd_host_model_i.idle;
    endtask
    task automatic src(input int k, input logic v);
        case (k)
            0: pin_b <= !v;
            1: wdt <= v;
            2: opc <= v;
            3: adr <= v;
            4: osc <= v;
            5: lvt <= v;
            6: stp <= v;
            default: dbi <= v;
        endcase
    endtask
    // Sources 8..10 are a bad service value, a closed-window write and a debug force
    task automatic hit(input int k, input logic [7:0] e);
        int n;
        n = 0;
        if (k < 8) begin
            @(posedge clk);
            src(k, 1'b1);
            @(posedge clk);
            src(k, 1'b0);
        end else begin
            rcd_host_model_i.acc(k != 10, k == 10, 1'b1, k == 10,
                                 k == 10 ? 8'h01 : (k == 8 ? rv : 8'h55));
            win_en <= (k == 9);
            win_open <= (k != 9);
            rcd_host_model_i.idle;
        end
        #1 chk("reset entry", 8'h01, {7'h0, mrst});
        while (mrst !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        win_en <= 1'b0;
        win_open <= 1'b1;
        if (n == 100)
            n_errors++;
        rd_exp(1'b1, e);
        $display("test %0d done", k);
    endtask
    initial begin
        {rst_b, wdt, opc, adr, osc, lvt, stp, dbi, win_en, rv} = '0;
        pin_b = 1'b1;
        win_open = 1'b1;
        tsel = 2'h1;
        void'($urandom(43806));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_exp(1'b1, 8'h82);
        rd_exp(1'b0, 8'h00);
        rcd_host_model_i.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h55);
        rcd_host_model_i.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'haa);
        rcd_host_model_i.idle;
        #1 chk("restart", 8'h01, {7'h0, restart});
        rcd_host_model_i.acc(1'b0, 1'b1, 1'b1, 1'b0, 8'h01);
        rcd_host_model_i.idle;
        #1 chk("user force", 8'h00, {7'h0, mrst});
        // Watchdog switched off: a bad value and a timeout must not reset
        tsel <= 2'h0;
        rcd_host_model_i.acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h12);
        wdt <= 1'b1;
        rcd_host_model_i.idle;
        wdt <= 1'b0;
        tsel <= 2'h1;
        #1 chk("watchdog off", 8'h00, {7'h0, mrst});
        rd_exp(1'b1, 8'h82);
        $display("test service done");
        do rv = 8'($urandom); while (rv == 8'h55 || rv == 8'haa);
        foreach (ex[k]) hit(k, ex[k]);
        repeat (3) @(posedge clk);
        conclude;
    end
    initial begin
        #100us;
        n_errors++;
        conclude;
    end
endmodule
bind rcd_reset_cause rcd_reset_cause_sva rcd_reset_cause_sva_i (.I_REF_CLK, .I_RST_B,
    .i_cause_sel, .i_force_sel, .i_wr, .i_rd, .i_wr_from_debug, .i_wdata,
    .i_watchdog_timeout_sel, .i_low_voltage_trip, .i_brownout_reset_en, .o_rdata,
    .o_rdata_valid, .o_reset_cause_reg, .o_mcu_reset, .o_wdog_restart);
